// ==== design/rcr_config_bank.sv ====
// How it works
// - Eight-bit registers reached by address over SPI.
// - Address 16 high nibble: lowpass bandwidth, default 1010.
// - Address 16 low nibble: channel filter, default 0011.
// - Address 17: centre code 0011, reserved nibble 1000.
// - Address 18 bit 7 enables OOK polyphase.
// - Address 18 bit 6 stops bit synchronizer.
// - Sync match tolerates zero to three bit errors.
// - Sync length 8 to 32, bytes from 22.
// - Address 20 shows signal level, read-only.
// - Address 21 bits 7-5: threshold decrement size.
// - Address 21 bits 4-2: threshold decrement rate.
// - Address 21 bits 1-0: averaging cutoff, host avoids 01/10.
// - Address 26 high nibble: interpolation cutoff, default 0111.
// - Address 26 bits 3-1: output power, default 001.
`default_nettype none
module rcr_config_bank (
	input  wire logic       CLK,
	input  wire logic       RESET_N,
	input  wire logic       SPI_SCK,
	input  wire logic       SPI_NSS_N,
	input  wire logic       SPI_MOSI,
	output logic            SPI_MISO,
	output logic            SPI_MISO_OE,
	input  wire logic [7:0] RSSI_VALUE,
	input  wire logic       RX_BIT,
	input  wire logic       RX_BIT_VALID,
	output logic            SYNC_FOUND,
	output logic [3:0]      LOWPASS_BW_CODE,
	output logic [3:0]      CHANNEL_FILTER_CODE,
	output logic [3:0]      POLYPHASE_CENTER_CODE,
	output logic            POLYPHASE_ENABLE,
	output logic            BITSYNC_DISABLE,
	output logic [2:0]      OOK_THRESHOLD_STEP,
	output logic [2:0]      OOK_THRESHOLD_DECAY_RATE,
	output logic [1:0]      OOK_AVERAGE_CUTOFF,
	output logic [3:0]      TX_INTERP_CUTOFF,
	output logic [2:0]      TX_POWER_CODE
);
	logic [2:0]  pins;
	logic        sck;
	logic        nss_n;
	logic        mosi;
	logic        sck_prev;
	logic [4:0]  bit_cnt;
	logic [7:0]  shift_in;
	logic [7:0]  shift_out;
	logic [6:0]  addr;
	logic        rd;
	logic [4:0]  next_bit_cnt;
	logic [7:0]  next_shift_in;
	logic [7:0]  next_shift_out;
	logic [6:0]  next_addr;
	logic        next_rd;
	logic        next_miso;
	logic        next_miso_oe;
	logic        wr_en;
	logic [7:0]  wr_data;
	logic [6:0]  cmd_addr;
	logic [7:0]  rd_byte;
	logic [7:0]  reg_lowpass;
	logic [7:0]  reg_center;
	logic [7:0]  reg_match;
	logic [7:0]  reg_rsvd;
	logic [7:0]  reg_level;
	logic [7:0]  reg_ook;
	logic [7:0]  reg_pat3;
	logic [7:0]  reg_pat2;
	logic [7:0]  reg_pat1;
	logic [7:0]  reg_pat0;
	logic [7:0]  reg_tx;
	logic [7:0]  next_lowpass;
	logic [7:0]  next_center;
	logic [7:0]  next_match;
	logic [7:0]  next_rsvd;
	logic [7:0]  next_ook;
	logic [7:0]  next_pat3;
	logic [7:0]  next_pat2;
	logic [7:0]  next_pat1;
	logic [7:0]  next_pat0;
	logic [7:0]  next_tx;
	logic [31:0] rx_shift;
	logic [31:0] next_rx_shift;
	logic        next_sync_found;
	logic [1:0]  sync_size;
	logic [1:0]  sync_tol;
	logic [5:0]  sync_errs;

	function automatic logic [31:0] pattern_mask(input logic [1:0] size);
		unique case (size)
			rcr_pkg::SIZE_8:  pattern_mask = 32'h0000_00ff;
			rcr_pkg::SIZE_16: pattern_mask = 32'h0000_ffff;
			rcr_pkg::SIZE_24: pattern_mask = 32'h00ff_ffff;
			default:          pattern_mask = 32'hffff_ffff;
		endcase
	endfunction : pattern_mask

	// Shorter words drop later bytes; the newest bit meets the last kept one.
	function automatic logic [31:0] pattern_word(input logic [1:0] size,
		input logic [31:0] bytes);
		unique case (size)
			rcr_pkg::SIZE_8:  pattern_word = {24'h00_0000, bytes[31:24]};
			rcr_pkg::SIZE_16: pattern_word = {16'h0000, bytes[31:16]};
			rcr_pkg::SIZE_24: pattern_word = {8'h00, bytes[31:8]};
			default:          pattern_word = bytes;
		endcase
	endfunction : pattern_word

	function automatic logic [5:0] count_ones(input logic [31:0] v);
		count_ones = 6'h00;
		for (int i = 0; i < rcr_pkg::PATTERN_W; i++) begin
			count_ones = 6'(count_ones + {5'h00, v[i]});
		end
	endfunction : count_ones

	rcr_pin_sync #(
		.WIDTH (3),
		.INIT  (3'h2)
	) u_pin_sync (
		.clk     (CLK),
		.reset_n (RESET_N),
		.pin_in  ({SPI_SCK, SPI_NSS_N, SPI_MOSI}),
		.level   (pins)
	);

	assign sck      = pins[2];
	assign nss_n    = pins[1];
	assign mosi     = pins[0];
	assign cmd_addr = {shift_in[5:0], mosi};

	always_comb begin
		unique case (cmd_addr)
			rcr_pkg::ADDR_LOWPASS: rd_byte = reg_lowpass;
			rcr_pkg::ADDR_CENTER:  rd_byte = reg_center;
			rcr_pkg::ADDR_MATCH:   rd_byte = reg_match;
			rcr_pkg::ADDR_RSVD:    rd_byte = reg_rsvd;
			rcr_pkg::ADDR_LEVEL:   rd_byte = reg_level;
			rcr_pkg::ADDR_OOK:     rd_byte = reg_ook;
			rcr_pkg::ADDR_PAT3:    rd_byte = reg_pat3;
			rcr_pkg::ADDR_PAT2:    rd_byte = reg_pat2;
			rcr_pkg::ADDR_PAT1:    rd_byte = reg_pat1;
			rcr_pkg::ADDR_PAT0:    rd_byte = reg_pat0;
			rcr_pkg::ADDR_TX:      rd_byte = reg_tx;
			default:               rd_byte = 8'h00;
		endcase
	end

	// Mode 0 framing: command byte (bit 7 set for read), then one data byte.
	always_comb begin
		next_bit_cnt   = bit_cnt;
		next_shift_in  = shift_in;
		next_shift_out = shift_out;
		next_addr      = addr;
		next_rd        = rd;
		next_miso      = SPI_MISO;
		next_miso_oe   = 1'b1;
		wr_en          = 1'b0;
		wr_data        = {shift_in[6:0], mosi};
		if (nss_n) begin
			next_bit_cnt = 5'h00;
			next_miso    = 1'b0;
			next_miso_oe = 1'b0;
		end else if (sck && !sck_prev && bit_cnt < rcr_pkg::BIT_FRAME_END) begin
			next_shift_in = {shift_in[6:0], mosi};
			next_bit_cnt  = 5'(bit_cnt + 5'h01);
			if (bit_cnt == rcr_pkg::BIT_CMD_LAST) begin
				next_rd        = shift_in[rcr_pkg::CMD_RD_BIT];
				next_addr      = cmd_addr;
				next_shift_out = rd_byte;
			end
			if (bit_cnt == rcr_pkg::BIT_FRAME_LAST && !rd) begin
				wr_en = 1'b1;
			end
		end else if (!sck && sck_prev && rd
			&& bit_cnt >= rcr_pkg::BIT_DATA_FIRST
			&& bit_cnt < rcr_pkg::BIT_FRAME_END) begin
			next_miso      = shift_out[7];
			next_shift_out = {shift_out[6:0], 1'b0};
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			sck_prev    <= 1'b0;
			bit_cnt     <= 5'h00;
			shift_in    <= 8'h00;
			shift_out   <= 8'h00;
			addr        <= 7'h00;
			rd          <= 1'b0;
			SPI_MISO    <= 1'b0;
			SPI_MISO_OE <= 1'b0;
		end else begin
			sck_prev    <= sck;
			bit_cnt     <= next_bit_cnt;
			shift_in    <= next_shift_in;
			shift_out   <= next_shift_out;
			addr        <= next_addr;
			rd          <= next_rd;
			SPI_MISO    <= next_miso;
			SPI_MISO_OE <= next_miso_oe;
		end
	end

	// Reserved fields are stored as written; the host keeps them at default.
	always_comb begin
		next_lowpass = reg_lowpass;
		next_center  = reg_center;
		next_match   = reg_match;
		next_rsvd    = reg_rsvd;
		next_ook     = reg_ook;
		next_pat3    = reg_pat3;
		next_pat2    = reg_pat2;
		next_pat1    = reg_pat1;
		next_pat0    = reg_pat0;
		next_tx      = reg_tx;
		if (wr_en) begin
			unique case (addr)
				rcr_pkg::ADDR_LOWPASS: next_lowpass = wr_data;
				rcr_pkg::ADDR_CENTER:  next_center  = wr_data;
				rcr_pkg::ADDR_MATCH:   next_match   = wr_data;
				rcr_pkg::ADDR_RSVD:    next_rsvd    = wr_data;
				rcr_pkg::ADDR_OOK:     next_ook     = wr_data;
				rcr_pkg::ADDR_PAT3:    next_pat3    = wr_data;
				rcr_pkg::ADDR_PAT2:    next_pat2    = wr_data;
				rcr_pkg::ADDR_PAT1:    next_pat1    = wr_data;
				rcr_pkg::ADDR_PAT0:    next_pat0    = wr_data;
				rcr_pkg::ADDR_TX:      next_tx      = wr_data;
				default:               next_tx      = reg_tx;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			reg_lowpass <= rcr_pkg::RST_LOWPASS;
			reg_center  <= rcr_pkg::RST_CENTER;
			reg_match   <= rcr_pkg::RST_MATCH;
			reg_rsvd    <= rcr_pkg::RST_RSVD;
			reg_level   <= rcr_pkg::RST_LEVEL;
			reg_ook     <= rcr_pkg::RST_OOK;
			reg_pat3    <= rcr_pkg::RST_PATTERN;
			reg_pat2    <= rcr_pkg::RST_PATTERN;
			reg_pat1    <= rcr_pkg::RST_PATTERN;
			reg_pat0    <= rcr_pkg::RST_PATTERN;
			reg_tx      <= rcr_pkg::RST_TX;
		end else begin
			reg_lowpass <= next_lowpass;
			reg_center  <= next_center;
			reg_match   <= next_match;
			reg_rsvd    <= next_rsvd;
			reg_level   <= RSSI_VALUE;
			reg_ook     <= next_ook;
			reg_pat3    <= next_pat3;
			reg_pat2    <= next_pat2;
			reg_pat1    <= next_pat1;
			reg_pat0    <= next_pat0;
			reg_tx      <= next_tx;
		end
	end

	assign sync_size = reg_match[rcr_pkg::SIZE_MSB:rcr_pkg::SIZE_LSB];
	assign sync_tol  = reg_match[rcr_pkg::TOL_MSB:rcr_pkg::TOL_LSB];

	always_comb begin
		next_rx_shift = RX_BIT_VALID ? {rx_shift[30:0], RX_BIT} : rx_shift;
		sync_errs = count_ones((next_rx_shift ^ pattern_word(sync_size,
			{reg_pat3, reg_pat2, reg_pat1, reg_pat0}))
			& pattern_mask(sync_size));
		next_sync_found = reg_match[rcr_pkg::SYNC_ON_BIT] && RX_BIT_VALID
			&& sync_errs <= {4'h0, sync_tol};
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			rx_shift   <= 32'h0000_0000;
			SYNC_FOUND <= 1'b0;
		end else begin
			rx_shift   <= next_rx_shift;
			SYNC_FOUND <= next_sync_found;
		end
	end

	assign LOWPASS_BW_CODE          = reg_lowpass[rcr_pkg::HI_MSB:rcr_pkg::HI_LSB];
	assign CHANNEL_FILTER_CODE      = reg_lowpass[rcr_pkg::LO_MSB:rcr_pkg::LO_LSB];
	assign POLYPHASE_CENTER_CODE    = reg_center[rcr_pkg::HI_MSB:rcr_pkg::HI_LSB];
	assign POLYPHASE_ENABLE         = reg_match[rcr_pkg::POLY_EN_BIT];
	assign BITSYNC_DISABLE          = reg_match[rcr_pkg::BSYNC_OFF_BIT];
	assign OOK_THRESHOLD_STEP       = reg_ook[rcr_pkg::STEP_MSB:rcr_pkg::STEP_LSB];
	assign OOK_THRESHOLD_DECAY_RATE = reg_ook[rcr_pkg::DECAY_MSB:rcr_pkg::DECAY_LSB];
	assign OOK_AVERAGE_CUTOFF       = reg_ook[rcr_pkg::AVG_MSB:rcr_pkg::AVG_LSB];
	assign TX_INTERP_CUTOFF         = reg_tx[rcr_pkg::HI_MSB:rcr_pkg::HI_LSB];
	assign TX_POWER_CODE            = reg_tx[rcr_pkg::PWR_MSB:rcr_pkg::PWR_LSB];

	default clocking @(posedge CLK); endclocking
	sequence s_write(logic [6:0] a);
		wr_en && addr == a;
	endsequence

	chk_lowpass_write: assert property (disable iff (!RESET_N)
		s_write(rcr_pkg::ADDR_LOWPASS) |=> LOWPASS_BW_CODE
		== $past(wr_data[7:4]) && CHANNEL_FILTER_CODE == $past(wr_data[3:0]))
		else $error("Lowpass register did not take the write.");
	chk_center_write: assert property (disable iff (!RESET_N)
		s_write(rcr_pkg::ADDR_CENTER) |=> reg_center == $past(wr_data))
		else $error("Centre register did not take the write.");
	chk_match_ctrl: assert property (disable iff (!RESET_N)
		s_write(rcr_pkg::ADDR_MATCH) |=> POLYPHASE_ENABLE == $past(wr_data[7])
		&& BITSYNC_DISABLE == $past(wr_data[6]))
		else $error("Match control bits did not follow the write.");
	chk_sync_quiet: assert property (disable iff (!RESET_N)
		!reg_match[rcr_pkg::SYNC_ON_BIT] || !RX_BIT_VALID |=> !SYNC_FOUND)
		else $error("Sync reported while off or without a bit.");
	chk_sync_exact: assert property (disable iff (!RESET_N)
		reg_match[rcr_pkg::SYNC_ON_BIT] && RX_BIT_VALID
		&& next_rx_shift[7:0] == reg_pat3 && sync_size == rcr_pkg::SIZE_8
		|=> SYNC_FOUND)
		else $error("Exact one-byte pattern was missed.");
	chk_level_ro: assert property (disable iff (!RESET_N)
		RESET_N |=> reg_level == $past(RSSI_VALUE))
		else $error("Signal level did not follow the measured value.");
	chk_ook_write: assert property (disable iff (!RESET_N)
		s_write(rcr_pkg::ADDR_OOK) |=> {OOK_THRESHOLD_STEP,
		OOK_THRESHOLD_DECAY_RATE, OOK_AVERAGE_CUTOFF} == $past(wr_data))
		else $error("Threshold register did not take the write.");
	chk_tx_write: assert property (disable iff (!RESET_N)
		s_write(rcr_pkg::ADDR_TX) |=> TX_INTERP_CUTOFF == $past(wr_data[7:4])
		&& TX_POWER_CODE == $past(wr_data[3:1]))
		else $error("Transmit register did not take the write.");
	chk_reset_values: assert property (
		!RESET_N |=> reg_lowpass == rcr_pkg::RST_LOWPASS
		&& reg_match == rcr_pkg::RST_MATCH && reg_tx == rcr_pkg::RST_TX
		&& reg_rsvd == rcr_pkg::RST_RSVD && reg_center == rcr_pkg::RST_CENTER)
		else $error("A register missed its reset default.");
	chk_read_load: assert property (disable iff (!RESET_N)
		!nss_n && sck && !sck_prev && bit_cnt == rcr_pkg::BIT_CMD_LAST
		|=> shift_out == $past(rd_byte) && bit_cnt == rcr_pkg::BIT_DATA_FIRST)
		else $error("Read data not loaded after command byte.");
endmodule : rcr_config_bank
`default_nettype wire

// ==== design/rcr_pkg.sv ====
`default_nettype none
package rcr_pkg;
	localparam int         REG_W          = 8;
	localparam int         PATTERN_W      = 32;
	localparam logic [6:0] ADDR_LOWPASS   = 7'h10;
	localparam logic [6:0] ADDR_CENTER    = 7'h11;
	localparam logic [6:0] ADDR_MATCH     = 7'h12;
	localparam logic [6:0] ADDR_RSVD      = 7'h13;
	localparam logic [6:0] ADDR_LEVEL     = 7'h14;
	localparam logic [6:0] ADDR_OOK       = 7'h15;
	localparam logic [6:0] ADDR_PAT3      = 7'h16;
	localparam logic [6:0] ADDR_PAT2      = 7'h17;
	localparam logic [6:0] ADDR_PAT1      = 7'h18;
	localparam logic [6:0] ADDR_PAT0      = 7'h19;
	localparam logic [6:0] ADDR_TX        = 7'h1a;
	localparam logic [7:0] RST_LOWPASS    = 8'ha3;
	localparam logic [7:0] RST_CENTER     = 8'h38;
	localparam logic [7:0] RST_MATCH      = 8'h18;
	localparam logic [7:0] RST_RSVD       = 8'h07;
	localparam logic [7:0] RST_OOK        = 8'h00;
	localparam logic [7:0] RST_PATTERN    = 8'h00;
	localparam logic [7:0] RST_TX         = 8'h72;
	localparam logic [7:0] RST_LEVEL      = 8'h00;
	localparam int         HI_MSB         = 7;
	localparam int         HI_LSB         = 4;
	localparam int         LO_MSB         = 3;
	localparam int         LO_LSB         = 0;
	localparam int         POLY_EN_BIT    = 7;
	localparam int         BSYNC_OFF_BIT  = 6;
	localparam int         SYNC_ON_BIT    = 5;
	localparam int         SIZE_MSB       = 4;
	localparam int         SIZE_LSB       = 3;
	localparam int         TOL_MSB        = 2;
	localparam int         TOL_LSB        = 1;
	localparam int         STEP_MSB       = 7;
	localparam int         STEP_LSB       = 5;
	localparam int         DECAY_MSB      = 4;
	localparam int         DECAY_LSB      = 2;
	localparam int         AVG_MSB        = 1;
	localparam int         AVG_LSB        = 0;
	localparam int         PWR_MSB        = 3;
	localparam int         PWR_LSB        = 1;
	localparam logic [1:0] SIZE_8         = 2'h0;
	localparam logic [1:0] SIZE_16        = 2'h1;
	localparam logic [1:0] SIZE_24        = 2'h2;
	localparam int         CMD_RD_BIT     = 6;
	localparam logic [4:0] BIT_CMD_LAST   = 5'h07;
	localparam logic [4:0] BIT_FRAME_LAST = 5'h0f;
	localparam logic [4:0] BIT_DATA_FIRST = 5'h08;
	localparam logic [4:0] BIT_FRAME_END  = 5'h10;
endpackage : rcr_pkg
`default_nettype wire

// ==== design/rcr_pin_sync.sv ====
`default_nettype none
// A level is taken only once the second and third stages agree, so a
// glitch caught by the first stage cannot reach the shifter.
module rcr_pin_sync #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_level;

	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_level[i] = (stage2[i] == stage3[i]) ? stage2[i] : level[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
			level  <= INIT;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			level  <= next_level;
		end
	end
endmodule : rcr_pin_sync
`default_nettype wire

// ==== design/rcr_dummy_placeholder_removed.sv ====
`default_nettype none
`default_nettype wire

// ==== tb/rcr_spi_host.sv ====
`default_nettype none
module rcr_spi_host #(
	parameter int HALF = 8
) (
	input  wire logic       clk,
	output logic            sck,
	output logic            nss_n,
	output logic            mosi,
	input  wire logic       miso,
	input  wire logic       miso_oe,
	output logic            rd_done,
	output logic [7:0]      rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sck = 1'b0;
		nss_n = 1'b1;
		mosi = 1'b0;
		rd_done = 1'b0;
		rd_data = 8'h00;
	end
	// One access per frame, command byte then data byte, MSB first.
	task automatic xfer(input logic [15:0] frame);
		int i;
		logic [7:0] rd;
		rd = 8'h00;
		nss_n = 1'b0;
		for (i = 15; i >= 0; i--) begin
			mosi = frame[i];
			repeat (HALF) @(negedge clk);
			sck = 1'b1;
			if (i < 8) rd = {rd[6:0], miso_oe ? miso : 1'bx};
			repeat (HALF) @(negedge clk);
			sck = 1'b0;
		end
		repeat (HALF) @(negedge clk);
		nss_n = 1'b1;
		// A released line must not keep showing the last bit.
		mosi = ~mosi;
		rd_data = rd;
		rd_done = frame[15];
		@(negedge clk);
		rd_done = 1'b0;
		repeat (HALF) @(negedge clk);
	endtask : xfer
endmodule : rcr_spi_host
`default_nettype wire

// ==== tb/rcr_config_bank_bench.sv ====
`default_nettype none
module rcr_config_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, reset_n, sck, nss_n, mosi, miso, miso_oe;
	logic       rx_bit, rx_valid, sync_found, rd_done, pe, bd;
	logic [7:0] rssi, rd_data;
	logic [3:0] bw, chf, pc, ic;
	logic [2:0] st, dr, pw;
	logic [1:0] ac;
	logic [7:0] shadow [16:26];
	logic [7:0] exp_q [$];
	logic [63:0] hist, w, rf, em, msk;
	logic [31:0] pat;
	int         failures, tests_run, nbits, a, k, s, t, i, e, n;

	rcr_config_bank DUT (.CLK(clk), .RESET_N(reset_n), .SPI_SCK(sck),
		.SPI_NSS_N(nss_n), .SPI_MOSI(mosi), .SPI_MISO(miso),
		.SPI_MISO_OE(miso_oe), .RSSI_VALUE(rssi), .RX_BIT(rx_bit),
		.RX_BIT_VALID(rx_valid), .SYNC_FOUND(sync_found),
		.LOWPASS_BW_CODE(bw), .CHANNEL_FILTER_CODE(chf),
		.POLYPHASE_CENTER_CODE(pc), .POLYPHASE_ENABLE(pe),
		.BITSYNC_DISABLE(bd), .OOK_THRESHOLD_STEP(st),
		.OOK_THRESHOLD_DECAY_RATE(dr), .OOK_AVERAGE_CUTOFF(ac),
		.TX_INTERP_CUTOFF(ic), .TX_POWER_CODE(pw));
	rcr_spi_host host (.clk(clk), .sck(sck), .nss_n(nss_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .rd_done(rd_done),
		.rd_data(rd_data));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string nm, input logic [7:0] ex,
		input logic [7:0] got);
		tests_run++;
		if (got !== ex) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask : check

	task automatic complete_run();
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	// Read data is judged when it appears, against the oldest note.
	always @(posedge clk) begin
		if (rd_done === 1'b1)
			check("read data", exp_q.pop_front(), rd_data);
	end

	// The host keeps reserved fields at defaults and avoids averaging 01/10.
	function automatic logic [7:0] legal(input int ad, input logic [7:0] v);
		case (ad)
			17: return {v[7:4], 4'h8};
			18: return {v[7:1], 1'b0};
			19: return 8'h07;
			21: return {v[7:2], {2{v[0]}}};
			26: return {v[7:1], 1'b0};
			default: return v;
		endcase
	endfunction : legal

	task automatic wr_reg(input logic [6:0] ad, input logic [7:0] d);
		host.xfer({1'b0, ad, d});
		if (ad >= 7'h10 && ad <= 7'h1a && ad != 7'h14)
			shadow[ad] = d;
	endtask : wr_reg

	task automatic rd_reg(input logic [6:0] ad, input logic [7:0] ex);
		exp_q.push_back(ex);
		host.xfer({1'b1, ad, 8'h00});
	endtask : rd_reg

	task automatic fields();
		check("lowpass", 8'(shadow[16][7:4]), 8'(bw));
		check("channel", 8'(shadow[16][3:0]), 8'(chf));
		check("center", 8'(shadow[17][7:4]), 8'(pc));
		check("poly on", 8'(shadow[18][7]), 8'(pe));
		check("bsync off", 8'(shadow[18][6]), 8'(bd));
		check("step", 8'(shadow[21][7:5]), 8'(st));
		check("decay", 8'(shadow[21][4:2]), 8'(dr));
		check("average", 8'(shadow[21][1:0]), 8'(ac));
		check("interp", 8'(shadow[26][7:4]), 8'(ic));
		check("power", 8'(shadow[26][3:1]), 8'(pw));
	endtask : fields

	task automatic do_reset();
		reset_n = 1'b0;
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		shadow[16] = rcr_pkg::RST_LOWPASS;
		shadow[17] = rcr_pkg::RST_CENTER;
		shadow[18] = rcr_pkg::RST_MATCH;
		shadow[19] = rcr_pkg::RST_RSVD;
		shadow[20] = rcr_pkg::RST_LEVEL;
		shadow[21] = rcr_pkg::RST_OOK;
		for (int j = 22; j <= 25; j++)
			shadow[j] = rcr_pkg::RST_PATTERN;
		shadow[26] = rcr_pkg::RST_TX;
	endtask : do_reset

	// The flag answers one cycle after the bit and lasts one cycle only.
	task automatic rx_send(input logic b);
		logic [63:0] rw, mk;
		int nb, errs;
		logic hit;
		rx_bit = b;
		rx_valid = 1'b1;
		hist = {hist[62:0], b};
		nbits++;
		nb = 8 * (int'(shadow[18][4:3]) + 1);
		mk = (64'h1 << nb) - 64'h1;
		rw = {32'h0, shadow[22], shadow[23], shadow[24], shadow[25]};
		rw = rw >> (32 - nb);
		errs = $countones((hist ^ rw) & mk);
		hit = shadow[18][5] && errs <= int'(shadow[18][2:1]);
		@(negedge clk);
		rx_valid = 1'b0;
		if (nbits > 32) check("sync", 8'(hit), 8'(sync_found));
		@(negedge clk);
		if (nbits > 32) check("sync idle", 8'h00, 8'(sync_found));
	endtask : rx_send

	initial begin
		#600000;
		failures++;
		complete_run();
	end

	initial begin
		failures = 0;
		tests_run = 0;
		nbits = 0;
		hist = '0;
		reset_n = 1'b0;
		rx_bit = 1'b0;
		rx_valid = 1'b0;
		rssi = 8'h5c;
		void'($urandom(1));
		do_reset();
		fields();
		for (a = 16; a <= 26; a++)
			rd_reg(7'(a), a == 20 ? rssi : shadow[a]);
		for (k = 0; k < 3; k++) begin
			rssi = 8'($urandom);
			for (a = 16; a <= 26; a++)
				if (a != 20) wr_reg(7'(a), legal(a, 8'($urandom)));
			wr_reg(7'h1b, 8'h5a);
			fields();
			for (a = 15; a <= 27; a++)
				rd_reg(7'(a), (a < 16 || a > 26) ? 8'h00 :
					a == 20 ? rssi : shadow[a]);
		end
		// Every size and tolerance, with errors at the limit when s+t is even and one past it when odd.
		for (s = 0; s < 5; s++) begin
			for (t = 0; t < 4; t++) begin
				pat = $urandom;
				for (i = 0; i < 4; i++)
					wr_reg(7'(22 + i), pat[31 - 8 * i -: 8]);
				wr_reg(7'h12, {2'b00, s < 4, 2'(s), 2'(t), 1'b0});
				n = 8 * ((s & 3) + 1);
				msk = (64'h1 << n) - 64'h1;
				rf = {32'h0, pat} >> (32 - n);
				e = t + ((s + t) % 2);
				em = '0;
				for (i = 0; i < e; i++)
					em[2 * i] = 1'b1;
				w = ({32'h0, $urandom} & ~msk) | (rf ^ em);
				for (i = 31; i >= 0; i--)
					rx_send(w[i]);
			end
		end
		do_reset();
		fields();
		rd_reg(7'h12, rcr_pkg::RST_MATCH);
		repeat (20) @(negedge clk);
		complete_run();
	end
endmodule : rcr_config_bank_bench
`default_nettype wire
